// *** acl_action_count_logic.sv ***
/*
  Per-port access-control action stage: rule table, priority and
  forwarding adjustment, remarking, and the count-mode counter.
  Assumes the matcher delivers one-cycle frame strobes on clk_i and a
  classic Wishbone master on the same clock.
*/
// Overview of operation
// - Priority mode 00 keeps QoS priority.
// - Mode 01 takes rule priority if higher.
// - Mode 10 takes rule priority if lower.
// - Mode 11 always takes rule priority.
// - Remark enable replaces PCP with remark level.
// - Map mode 00 keeps lookup map.
// - Map mode 01 ORs rule and lookup maps.
// - Map mode 10 ANDs rule and lookup maps.
// - Map mode 11 uses rule map only.
// - Map bit 0 is port 1; set forwards.
// - Count mode reads count, unit, algorithm fields.
// - Unit bit selects microsecond or millisecond tick.
// - Timeout algorithm loads and decrements 11-bit counter.
// - Timeout expiry raises the port interrupt.
// - Packet algorithm counts matched frames, ignores unit.
// - Terminal count raises interrupt and clears counter in the same cycle.
// - Table holds sixteen entries of all fields.
// - Fields independent except paired in count mode.
// - Filtering rules never raise an interrupt.
// - Per-port interrupt status and mask bits.
// - Count value overlays priority, remark and map mode fields.
// - Count frames need MAC and type match.
`timescale 1ns/1ns
module acl_action_count_logic #(
  parameter int unsigned MS_CYCLES = acl_action_pkg::CYCLES_PER_MS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire acl_action_pkg::frame_in_t frame_i,
  output acl_action_pkg::action_out_t result_o,
  output logic port_irq_o
);

  typedef enum logic [1:0] {
    CNT_IDLE,
    CNT_TIMING,
    CNT_PACKETS
  } cnt_state_t;

  // Byte-lane merge for table writes
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0] sel);
    logic [31:0] r;
    r = old_w;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge_bytes

  function automatic logic is_count_mode(input logic [3:0] m);
    return (m[acl_action_pkg::RULE_MODE_LSB +: 2] == acl_action_pkg::RULE_MODE_L2) &&
           (m[acl_action_pkg::COMPARE_SEL_LSB +: 2] == acl_action_pkg::COMPARE_COUNT);
  endfunction : is_count_mode

  // Rule table
  logic [acl_action_pkg::ACTION_W-1:0] action_mem [acl_action_pkg::RULE_COUNT];
  logic [3:0] mode_mem [acl_action_pkg::RULE_COUNT];

  logic irq_status;
  logic irq_mask;
  logic [acl_action_pkg::COUNT_W-1:0] counter;
  logic [3:0] cnt_entry;
  cnt_state_t cnt_state;
  cnt_state_t next_cnt_state;
  logic [3:0] us_div;
  logic [15:0] ms_div;
  logic [31:0] next_rdata;
  logic [acl_action_pkg::COUNT_W-1:0] next_counter;

  // Bus decode
  wire logic bus_req = wb_cyc_i && wb_stb_i;
  wire logic bus_write = bus_req && wb_we_i && wb_ack_o;
  wire logic [3:0] word_idx = wb_adr_i[5:2];
  wire logic hit_action = (wb_adr_i[7:6] == acl_action_pkg::ACTION_BASE[7:6]);
  wire logic hit_mode = (wb_adr_i[7:6] == acl_action_pkg::MODE_BASE[7:6]);
  wire logic hit_status = (wb_adr_i == acl_action_pkg::IRQ_STATUS_ADDR);
  wire logic hit_mask = (wb_adr_i == acl_action_pkg::IRQ_MASK_ADDR);
  wire logic hit_counter = (wb_adr_i == acl_action_pkg::COUNTER_ADDR);
  wire logic [31:0] action_word = {{(32 - acl_action_pkg::ACTION_W){1'b0}},
                                   action_mem[word_idx]};
  wire logic [31:0] mode_word = {28'h0000000, mode_mem[word_idx]};
  wire logic [31:0] action_merged = merge_bytes(action_word, wb_dat_i, wb_sel_i);
  wire logic [31:0] mode_merged = merge_bytes(mode_word, wb_dat_i, wb_sel_i);
  wire logic status_clear = bus_write && hit_status && wb_sel_i[0] && wb_dat_i[0];
  // Writes commit on the acked edge only, so each ack writes once; a held request is acked and writes every other cycle
  wire logic write_action = bus_write && hit_action;
  wire logic write_mode = bus_write && hit_mode;
  wire logic write_mask = bus_write && hit_mask && wb_sel_i[0];

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit_action) begin
      next_rdata = action_word;
    end else if (hit_mode) begin
      next_rdata = mode_word;
    end else if (hit_status) begin
      next_rdata = {31'h0000_0000, irq_status};
    end else if (hit_mask) begin
      next_rdata = {31'h0000_0000, irq_mask};
    end else if (hit_counter) begin
      next_rdata = {21'h000000, counter};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req && !wb_ack_o;
      wb_dat_o <= next_rdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < acl_action_pkg::RULE_COUNT; i++) begin
        action_mem[i] <= acl_action_pkg::ACTION_RESET[acl_action_pkg::ACTION_W-1:0];
        mode_mem[i] <= acl_action_pkg::MODE_RESET;
      end
    end else if (write_action) begin
      action_mem[word_idx] <= action_merged[acl_action_pkg::ACTION_W-1:0];
    end else if (write_mode) begin
      mode_mem[word_idx] <= mode_merged[3:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask <= 1'b0;
    end else if (write_mask) begin
      irq_mask <= wb_dat_i[0];
    end
  end

  // Frame action decode
  wire logic [acl_action_pkg::ACTION_W-1:0] act = action_mem[frame_i.rule_index];
  wire logic entry_count = is_count_mode(mode_mem[frame_i.rule_index]);
  wire logic [1:0] prio_mode = act[acl_action_pkg::PRIO_MODE_LSB +: 2];
  wire logic [2:0] rule_prio = act[acl_action_pkg::PRIO_LSB +: 3];
  wire logic remark_enable = act[acl_action_pkg::REMARK_EN_BIT];
  wire logic [2:0] remark_level = act[acl_action_pkg::REMARK_LSB +: 3];
  wire logic [1:0] forward_map_mode = act[acl_action_pkg::MAP_MODE_LSB +: 2];
  // Bit 0 of the rule map is port 1
  wire logic [acl_action_pkg::PORT_COUNT-1:0] rule_map =
    act[acl_action_pkg::FORWARD_LSB +: acl_action_pkg::PORT_COUNT];
  wire logic filter_hit = frame_i.valid && frame_i.rule_hit && !entry_count;
  wire logic remark_now = filter_hit && remark_enable;

  logic [2:0] next_prio;
  logic [acl_action_pkg::PORT_COUNT-1:0] next_map;

  always_comb begin
    next_prio = frame_i.qos_prio;
    next_map = frame_i.lookup_map;
    if (filter_hit) begin
      case (prio_mode)
        acl_action_pkg::MODE_KEEP: next_prio = frame_i.qos_prio;
        acl_action_pkg::MODE_RAISE: begin
          if (rule_prio > frame_i.qos_prio) begin
            next_prio = rule_prio;
          end
        end
        acl_action_pkg::MODE_LOWER: begin
          if (rule_prio < frame_i.qos_prio) begin
            next_prio = rule_prio;
          end
        end
        acl_action_pkg::MODE_FORCE: next_prio = rule_prio;
        default: next_prio = frame_i.qos_prio;
      endcase
      case (forward_map_mode)
        acl_action_pkg::MODE_KEEP: next_map = frame_i.lookup_map;
        acl_action_pkg::MODE_RAISE: next_map = rule_map | frame_i.lookup_map;
        acl_action_pkg::MODE_LOWER: next_map = rule_map & frame_i.lookup_map;
        acl_action_pkg::MODE_FORCE: next_map = rule_map;
        default: next_map = frame_i.lookup_map;
      endcase
    end
  end

  // Fields follow frame_i every cycle; only valid marks a result
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_o <= '0;
    end else begin
      result_o.valid <= frame_i.valid;
      result_o.prio <= next_prio;
      result_o.remark <= remark_now;
      result_o.pcp <= remark_now ? remark_level : 3'h0;
      result_o.forward_map <= next_map;
    end
  end

  // Count mode: entry match and action are used together
  wire logic count_qualify = frame_i.valid && frame_i.rule_hit && entry_count &&
                             frame_i.mac_match && frame_i.type_match;
  wire logic [acl_action_pkg::ACTION_W-1:0] cnt_act =
    count_qualify ? act : action_mem[cnt_entry];
  // Count value overlays the priority, remark and map mode bits
  wire logic [acl_action_pkg::COUNT_W-1:0] count_value =
    cnt_act[acl_action_pkg::COUNT_LSB +: acl_action_pkg::COUNT_W];
  wire logic count_time_unit = cnt_act[acl_action_pkg::TIME_UNIT_BIT];
  wire logic counter_algorithm_select = cnt_act[acl_action_pkg::ALGO_BIT];

  // Free-running prescalers; first tick after arming may come early by up to one unit
  wire logic us_tick = (us_div == 4'(acl_action_pkg::CYCLES_PER_US - 1));
  wire logic ms_tick = (ms_div == 16'(MS_CYCLES - 1));
  wire logic unit_tick = count_time_unit ? ms_tick : us_tick;
  // A timer value left in the counter must never count as packets
  wire logic [acl_action_pkg::COUNT_W-1:0] pkt_base =
    (cnt_state == CNT_PACKETS) ? counter : 11'h000;
  wire logic [acl_action_pkg::COUNT_W-1:0] pkt_next = pkt_base + 11'h001;
  wire logic timer_expire = (cnt_state == CNT_TIMING) && !count_qualify && unit_tick &&
                            (counter <= 11'h001);
  wire logic pkt_terminal = count_qualify && counter_algorithm_select &&
                            (pkt_next == count_value);
  // Only count-mode events reach the status bit
  wire logic irq_event = timer_expire || pkt_terminal;
  wire logic pkt_step = count_qualify && counter_algorithm_select;
  wire logic [acl_action_pkg::COUNT_W-1:0] pkt_value =
    pkt_terminal ? 11'h000 : pkt_next;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      us_div <= 4'h0;
      ms_div <= 16'h0000;
    end else begin
      us_div <= us_tick ? 4'h0 : us_div + 4'h1;
      ms_div <= ms_tick ? 16'h0000 : ms_div + 16'h0001;
    end
  end

  // Timing rearms on every qualifying frame; expiry falls back to idle
  wire cnt_state_t armed_state = counter_algorithm_select ? CNT_PACKETS : CNT_TIMING;

  always_comb begin
    next_cnt_state = cnt_state;
    case (cnt_state)
      CNT_IDLE, CNT_PACKETS: begin
        if (count_qualify) begin
          next_cnt_state = armed_state;
        end
      end
      CNT_TIMING: begin
        if (count_qualify) begin
          next_cnt_state = armed_state;
        end else if (timer_expire) begin
          next_cnt_state = CNT_IDLE;
        end
      end
      default: next_cnt_state = CNT_IDLE;
    endcase
  end

  // A frame beats a tick in the same cycle, so no expiry follows a reload
  always_comb begin
    next_counter = counter;
    case (cnt_state)
      CNT_TIMING: begin
        if (pkt_step) begin
          next_counter = pkt_value;
        end else if (count_qualify) begin
          next_counter = count_value;
        end else if (timer_expire) begin
          next_counter = 11'h000;
        end else if (unit_tick) begin
          next_counter = counter - 11'h001;
        end
      end
      CNT_PACKETS: begin
        if (pkt_step) begin
          next_counter = pkt_value;
        end else if (count_qualify) begin
          next_counter = count_value;
        end
      end
      CNT_IDLE: begin
        if (pkt_step) begin
          next_counter = pkt_value;
        end else if (count_qualify) begin
          next_counter = count_value;
        end
      end
      default: next_counter = 11'h000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_state <= CNT_IDLE;
      counter <= 11'h000;
      cnt_entry <= 4'h0;
    end else begin
      cnt_state <= next_cnt_state;
      counter <= next_counter;
      if (count_qualify) begin
        cnt_entry <= frame_i.rule_index;
      end
    end
  end

  // Sticky status; a new event beats a clear in the same cycle
  wire logic next_irq_status = irq_event || (irq_status && !status_clear);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status <= 1'b0;
      port_irq_o <= 1'b0;
    end else begin
      if (irq_event) begin
        irq_status <= 1'b1;
      end else if (status_clear) begin
        irq_status <= 1'b0;
      end
      port_irq_o <= next_irq_status && irq_mask;
    end
  end

endmodule : acl_action_count_logic

// *** acl_action_pkg.sv ***
/*
  Shared constants and carriers for the access-control action stage.
  Assumes one 10 MHz core clock and a classic Wishbone register port.
*/
package acl_action_pkg;

  localparam int unsigned RULE_COUNT = 16;
  localparam int unsigned PORT_COUNT = 7;
  localparam int unsigned WB_ADDR_W = 8;

  // Register byte addresses
  localparam logic [7:0] ACTION_BASE = 8'h00;
  localparam logic [7:0] MODE_BASE = 8'h40;
  localparam logic [7:0] IRQ_STATUS_ADDR = 8'h80;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'h84;
  localparam logic [7:0] COUNTER_ADDR = 8'h88;

  // Action word, non-count layout
  localparam int unsigned PRIO_MODE_LSB = 0;
  localparam int unsigned PRIO_LSB = 2;
  localparam int unsigned REMARK_EN_BIT = 5;
  localparam int unsigned REMARK_LSB = 6;
  localparam int unsigned MAP_MODE_LSB = 9;
  localparam int unsigned FORWARD_LSB = 11;
  localparam int unsigned ACTION_W = 18;
  // Action word, count layout
  localparam int unsigned COUNT_LSB = 0;
  localparam int unsigned COUNT_W = 11;
  localparam int unsigned TIME_UNIT_BIT = 11;
  localparam int unsigned ALGO_BIT = 12;
  // Mode word layout
  localparam int unsigned RULE_MODE_LSB = 0;
  localparam int unsigned COMPARE_SEL_LSB = 2;

  localparam logic [1:0] RULE_MODE_L2 = 2'h1;
  localparam logic [1:0] COMPARE_COUNT = 2'h0;
  localparam logic [1:0] MODE_KEEP = 2'h0;
  localparam logic [1:0] MODE_RAISE = 2'h1;
  localparam logic [1:0] MODE_LOWER = 2'h2;
  localparam logic [1:0] MODE_FORCE = 2'h3;

  localparam logic [31:0] ACTION_RESET = 32'h0000_0000;
  localparam logic [3:0] MODE_RESET = 4'h0;

  // Timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned TICK_US_NS = 1000;
  localparam int unsigned TICK_MS_US = 1000;
  localparam int unsigned CYCLES_PER_US = (CLK_HZ / 1_000_000) * TICK_US_NS / 1000;
  localparam int unsigned CYCLES_PER_MS = CYCLES_PER_US * TICK_MS_US;

  typedef struct packed {
    logic valid;
    logic rule_hit;
    logic [3:0] rule_index;
    logic mac_match;
    logic type_match;
    logic [2:0] qos_prio;
    logic [PORT_COUNT-1:0] lookup_map;
  } frame_in_t;

  typedef struct packed {
    logic valid;
    logic [2:0] prio;
    logic remark;
    logic [2:0] pcp;
    logic [PORT_COUNT-1:0] forward_map;
  } action_out_t;

endpackage : acl_action_pkg

// *** acl_action_props.sv ***
/*
  Port checker for the action stage.
  Bound to the design top; sees only its ports.
*/
`timescale 1ns/1ns
module acl_action_props #(
  parameter int unsigned MS_CYCLES = 10000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire acl_action_pkg::frame_in_t frame_i,
  input wire acl_action_pkg::action_out_t result_o,
  input wire logic port_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_miss;
    frame_i.valid && !frame_i.rule_hit;
  endsequence
  a_ack_after_req: assert property (s_req |=> wb_ack_o)
    else $error("ack missing");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_result_lag: assert property (frame_i.valid |=> result_o.valid)
    else $error("result missing");
  a_result_cause: assert property (result_o.valid |-> $past(frame_i.valid))
    else $error("result without frame");
  a_miss_prio: assert property (s_miss |=> result_o.prio == $past(frame_i.qos_prio))
    else $error("miss priority changed");
  a_miss_map: assert property (s_miss |=> result_o.forward_map == $past(frame_i.lookup_map))
    else $error("miss map changed");
  a_pcp_quiet: assert property (result_o.valid && !result_o.remark |-> result_o.pcp == 3'h0)
    else $error("pcp without remark");
  a_irq_clear_cause: assert property ($fell(port_irq_o) |->
    $past(wb_we_i && wb_ack_o) || $past(wb_we_i && wb_ack_o, 2))
    else $error("irq dropped without write");
  a_counter_width: assert property (wb_ack_o && !wb_we_i &&
    wb_adr_i == acl_action_pkg::COUNTER_ADDR |-> wb_dat_o[31:11] == 21'h0)
    else $error("counter wider than 11 bits");
  a_mask_off_quiet: assert property (wb_we_i && wb_ack_o && !wb_dat_i[0] &&
    wb_sel_i[0] && wb_adr_i == acl_action_pkg::IRQ_MASK_ADDR |-> ##2 !port_irq_o)
    else $error("irq left on after mask off");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'hA0 |->
    wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
endmodule : acl_action_props

bind acl_action_count_logic acl_action_props #(.MS_CYCLES(MS_CYCLES)) u_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .frame_i(frame_i), .result_o(result_o),
  .port_irq_o(port_irq_o)
);

// *** acl_lookup_model.sv ***
/*
  Model of the lookup and QoS stage that feeds frames to the action stage.
  Same clock as the design; the bench stages a frame and pulses go_i.
*/
`timescale 1ns/1ns
module acl_lookup_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire acl_action_pkg::frame_in_t stage_i,
  output acl_action_pkg::frame_in_t frame_o
);
  initial frame_o = '0;
  // Idle fields toggle so stale data never passes for a frame
  always @(posedge clk_i) begin
    if (go_i) begin
      frame_o <= stage_i;
    end else begin
      frame_o <= ~frame_o;
      frame_o.valid <= 1'b0;
    end
  end
endmodule : acl_lookup_model

// *** acl_action_count_logic_test.sv ***
/*
  Self-checking bench for the action stage.
  Drives Wishbone and the lookup model on one 10 MHz clock.
*/
`timescale 1ns/1ns
module acl_action_count_logic_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic go = 1'b0;
  logic type_ok = 1'b1;
  logic [3:0] sel = 4'hF;
  logic irq;
  acl_action_pkg::frame_in_t stage = '0;
  acl_action_pkg::frame_in_t frame;
  acl_action_pkg::action_out_t res;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cycles = 0;

  acl_action_count_logic #(.MS_CYCLES(20)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .frame_i(frame), .result_o(res), .port_irq_o(irq)
  );
  acl_lookup_model i_model (.clk_i(clk_i), .go_i(go), .stage_i(stage), .frame_o(frame));

  initial begin
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch = n_mismatch + 1;
      summarize();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= s;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hF, q);
  endtask : wr

  task automatic wr_lanes(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    bus(1'b1, a, d, s, q);
  endtask : wr_lanes

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hF, q);
    check(q, e);
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask : idle

  task automatic send(input logic [3:0] i, input logic h, input logic m, input logic [2:0] q);
    @(posedge clk_i);
    stage <= '{1'b1, h, i, m, type_ok, q, 7'h33};
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    idle(1);
  endtask : send

  task automatic t_filter();
    logic [1:0] md;
    logic [2:0] q;
    logic [2:0] p;
    logic [6:0] m;
    logic [31:0] act;
    rd(8'hA0, 32'h0);
    wr(8'hA0, 32'hFFFF_FFFF);
    rd(8'hA0, 32'h0);
    rd(acl_action_pkg::MODE_BASE + 8'h3C, 32'h0);
    wr(acl_action_pkg::MODE_BASE + 8'h3C, 32'hD);
    wr(acl_action_pkg::IRQ_MASK_ADDR, 32'h1);
    for (int k = 0; k < 8; k++) begin
      md = k[2:1];
      q = k[0] ? 3'h6 : 3'h2;
      act = {14'h0, 7'h55, md, 3'h5, md[0], 3'h4, md};
      wr(acl_action_pkg::ACTION_BASE + 8'h3C, act);
      rd(acl_action_pkg::ACTION_BASE + 8'h3C, act);
      send(4'hF, 1'b1, 1'b1, q);
      p = (md == 2'h3 || (md == 2'h1 && q < 3'h4) || (md == 2'h2 && q > 3'h4)) ? 3'h4 : q;
      m = md == 2'h0 ? 7'h33 : md == 2'h1 ? 7'h77 : md == 2'h2 ? 7'h11 : 7'h55;
      check({28'h0, res.valid, res.prio}, {28'h0, 1'b1, p});
      check({25'h0, res.forward_map}, {25'h0, m});
      check({28'h0, res.remark, res.pcp}, {28'h0, md[0], md[0] ? 3'h5 : 3'h0});
    end
    send(4'hF, 1'b0, 1'b1, 3'h2);
    check({29'h0, res.prio}, 32'h2);
    check({31'h0, irq}, 32'h0);
    wr(acl_action_pkg::ACTION_BASE + 8'h3C, 32'h0);
    wr_lanes(acl_action_pkg::ACTION_BASE + 8'h3C, 32'hFFFF_FFFF, 4'h6);
    rd(acl_action_pkg::ACTION_BASE + 8'h3C, 32'h0003_FF00);
    wr(acl_action_pkg::IRQ_MASK_ADDR, 32'h0);
  endtask : t_filter

  task automatic t_packet();
    wr(acl_action_pkg::MODE_BASE + 8'h0C, 32'h1);
    wr(acl_action_pkg::ACTION_BASE + 8'h0C, 32'h1003);
    send(4'h3, 1'b1, 1'b1, 3'h2);
    check({28'h0, res.remark, res.prio}, 32'h2);
    send(4'h3, 1'b1, 1'b0, 3'h2);
    type_ok = 1'b0;
    send(4'h3, 1'b1, 1'b1, 3'h2);
    type_ok = 1'b1;
    send(4'h3, 1'b1, 1'b1, 3'h2);
    rd(acl_action_pkg::COUNTER_ADDR, 32'h2);
    send(4'h3, 1'b1, 1'b1, 3'h2);
    rd(acl_action_pkg::IRQ_STATUS_ADDR, 32'h1);
    rd(acl_action_pkg::COUNTER_ADDR, 32'h0);
    check({31'h0, irq}, 32'h0);
    wr(acl_action_pkg::IRQ_MASK_ADDR, 32'h1);
    idle(1);
    check({31'h0, irq}, 32'h1);
    wr_lanes(acl_action_pkg::IRQ_STATUS_ADDR, 32'h1, 4'hE);
    idle(1);
    check({31'h0, irq}, 32'h1);
    wr(acl_action_pkg::IRQ_STATUS_ADDR, 32'h1);
    idle(1);
    check({31'h0, irq}, 32'h0);
  endtask : t_packet

  task automatic wait_irq(input int n);
    for (int k = 0; k < n && irq !== 1'b1; k++) idle(0);
    check({31'h0, irq}, 32'h1);
    wr(acl_action_pkg::IRQ_STATUS_ADDR, 32'h1);
  endtask : wait_irq

  task automatic t_timeout();
    wr(acl_action_pkg::ACTION_BASE + 8'h0C, 32'h0005);
    send(4'h3, 1'b1, 1'b1, 3'h2);
    idle(25);
    check({31'h0, irq}, 32'h0);
    send(4'h3, 1'b1, 1'b1, 3'h2);
    idle(35);
    check({31'h0, irq}, 32'h0);
    wait_irq(30);
    wr(acl_action_pkg::ACTION_BASE + 8'h0C, 32'h0803);
    send(4'h3, 1'b1, 1'b1, 3'h2);
    idle(32);
    check({31'h0, irq}, 32'h0);
    wait_irq(40);
  endtask : t_timeout

  task automatic summarize();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_filter();
    t_packet();
    t_timeout();
    summarize();
  end
endmodule : acl_action_count_logic_test
